// [src/fpr_defs.svh]
// Constants for the fan drive ramp and floor configuration block.
// Assumes a 50 MHz core clock; included by its bare name.
`ifndef FPR_DEFS_SVH
`define FPR_DEFS_SVH

// Register addresses on the internal register port
`define FPR_ADDR_CFG_ONE 8'h62
`define FPR_ADDR_CFG_TWO 8'h63

// Power-on values of both configuration registers
`define FPR_CFG_ONE_RESET 8'h00
`define FPR_CFG_TWO_RESET 8'h00

// Field positions in the first configuration register
`define FPR_RATE_LSB 0
`define FPR_RATE_MSB 2
`define FPR_RAMP_EN_BIT 3
`define FPR_SYNC_SEL_BIT 4
`define FPR_FLOOR_ONE_BIT 5
`define FPR_FLOOR_TWO_BIT 6
`define FPR_FLOOR_THREE_BIT 7

// Duty increments per time slot for rate codes 0 to 7
`define FPR_INC_CODE0 8'h01
`define FPR_INC_CODE1 8'h02
`define FPR_INC_CODE2 8'h03
`define FPR_INC_CODE3 8'h04
`define FPR_INC_CODE4 8'h08
`define FPR_INC_CODE5 8'h0C
`define FPR_INC_CODE6 8'h18
`define FPR_INC_CODE7 8'h30

// Behaviour codes that are not temperature driven
`define FPR_BHV_FULL 3'h3
`define FPR_BHV_OFF 3'h4
`define FPR_BHV_MANUAL 3'h7

// Zero duty
`define FPR_DUTY_ZERO 8'h00

// Clock rate and ramp time slot
`define FPR_CLK_HZ 50000000
`define FPR_SLOT_TIME_US 205000
`define FPR_SLOT_CYCLES ((`FPR_SLOT_TIME_US * (`FPR_CLK_HZ / 1000000)))

`endif

// [src/fpr_floor.sv]
// Floor select for one fan drive: picks calculated, zero or minimum duty.
// Assumes below_floor_in is already qualified by the temperature logic.
`timescale 1ns/100ps
`default_nettype none
`include "fpr_defs.svh"

module fpr_floor
   import fpr_pkg::*;
(
   input wire fpr_bhv_t behaviour_in,
   input wire logic below_floor_in,
   input wire logic floor_select_in,
   input wire fpr_duty_t calc_duty_in,
   input wire fpr_duty_t min_duty_in,
   output logic auto_out,
   output fpr_duty_t target_out
);

   // Automatic only when a temperature source drives the drive
   always_comb begin
      auto_out = (behaviour_in != `FPR_BHV_FULL) &&
                 (behaviour_in != `FPR_BHV_OFF) &&
                 (behaviour_in != `FPR_BHV_MANUAL);
   end

   // Floor only matters in automatic control below start temp
   always_comb begin
      target_out = calc_duty_in;
      if (auto_out && below_floor_in) begin
         // Off or held at minimum, as software chose
         target_out = floor_select_in ? min_duty_in
                                      : `FPR_DUTY_ZERO;
      end
   end

endmodule : fpr_floor

`default_nettype wire

// [src/fpr_pkg.sv]
// Types shared by the fan drive ramp and floor configuration block.
// Assumes the constants header is available on the include path.
package fpr_pkg;

   // One fan drive duty value, 0 to 255
   typedef logic [7:0] fpr_duty_t;

   // Ramp rate code
   typedef logic [2:0] fpr_rate_t;

   // Behaviour select code of one drive
   typedef logic [2:0] fpr_bhv_t;

   // Time slot divider count
   typedef logic [23:0] fpr_slot_cnt_t;

   // Layout of the first configuration register
   typedef struct packed {
      logic floor_three; // Floor select, drive three
      logic floor_two; // Floor select, drive two
      logic floor_one; // Floor select, drive one
      logic sync_sel; // Speed input two gated to drive three
      logic ramp_en; // Ramp enable, drive one
      fpr_rate_t rate; // Ramp rate code, drive one
   } fpr_cfg_one_t;

endpackage : fpr_pkg

// [src/fpr_ramp.sv]
// Ramp stepper for drive one: walks the duty toward its target.
// Assumes slot_pulse is a one-cycle strobe from the top's divider.
`timescale 1ns/100ps
`default_nettype none
`include "fpr_defs.svh"

module fpr_ramp
   import fpr_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   fpr_ramp_if.step ramp
);

   // All state of the stepper
   typedef struct packed {
      fpr_duty_t duty; // Present ramped duty
   } fpr_ramp_state_t;

   fpr_ramp_state_t state; // Registered state
   fpr_ramp_state_t next_state; // Next value
   fpr_duty_t inc; // Increment for the selected rate
   logic [8:0] gap; // Distance to target, unsigned

   // Rate code to step size
   always_comb begin
      case (ramp.rate)
         3'h0: inc = `FPR_INC_CODE0;
         3'h1: inc = `FPR_INC_CODE1;
         3'h2: inc = `FPR_INC_CODE2;
         3'h3: inc = `FPR_INC_CODE3;
         3'h4: inc = `FPR_INC_CODE4;
         3'h5: inc = `FPR_INC_CODE5;
         3'h6: inc = `FPR_INC_CODE6;
         3'h7: inc = `FPR_INC_CODE7;
         default: inc = `FPR_INC_CODE0;
      endcase
   end

   // Step toward target, never overshooting it
   always_comb begin
      next_state = state;
      gap = 9'h000;
      if (!ramp.enable) begin
         // No ramping: jump straight to the new value
         next_state.duty = ramp.target;
      end else if (ramp.slot_pulse) begin
         if (ramp.target > state.duty) begin
            gap = {1'b0, ramp.target} - {1'b0, state.duty};
            // Clamp the last step so the target is hit exactly
            if (gap <= {1'b0, inc}) begin
               next_state.duty = ramp.target;
            end else begin
               next_state.duty = state.duty + inc;
            end
         end else if (ramp.target < state.duty) begin
            gap = {1'b0, state.duty} - {1'b0, ramp.target};
            if (gap <= {1'b0, inc}) begin
               next_state.duty = ramp.target;
            end else begin
               next_state.duty = state.duty - inc;
            end
         end
      end
   end

   // Register the state
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign ramp.duty = state.duty;

endmodule : fpr_ramp

`default_nettype wire

// [src/fpr_ramp_if.sv]
// Carrier between the top and the drive one ramp stepper.
// Assumes one clock domain; no clocking block.
`timescale 1ns/100ps
`default_nettype none

interface fpr_ramp_if;
   import fpr_pkg::*;

   fpr_duty_t target; // Duty the drive should reach
   fpr_rate_t rate; // Selected ramp rate
   logic enable; // Ramping active
   logic slot_pulse; // One-cycle time slot strobe
   fpr_duty_t duty; // Current ramped duty

   // Top drives the request side
   modport ctrl (
      output target,
      output rate,
      output enable,
      output slot_pulse,
      input duty
   );

   // Stepper answers with the duty
   modport step (
      input target,
      input rate,
      input enable,
      input slot_pulse,
      output duty
   );
endinterface : fpr_ramp_if

`default_nettype wire

// [src/fpr_top.sv]
// Fan drive ramp and floor configuration: two config registers, the
// drive one ramp, floor selects for three drives and speed input gating.
// Assumes the register port is driven by the serial bus front end and
// that duty, minimum duty and temperature flags arrive synchronous.
//
// Contract
// - Drive one moves gradually toward new duty.
// - Rate codes give increments 1,2,3,4,8,12,24,48.
// - Ramping applies only while ramp enable set.
// - Sync set gates inputs two to four.
// - Sync clear gates only inputs three, four.
// - Drive one floor: zero or minimum duty.
// - Drive two floor: zero or minimum duty.
// - Drive three floor: zero or minimum duty.
// - Lock set makes registers ignore writes.
// - Second register at 0x63, resets zero.
// - First register at 0x62, resets zero.
// - Automatic control only for temperature sources.
`timescale 1ns/100ps
`default_nettype none
`include "fpr_defs.svh"

module fpr_top
   import fpr_pkg::*;
#(
   // Time slot length in clock cycles; shorten for simulation
   parameter fpr_slot_cnt_t SLOT_CYCLES = 24'(`FPR_SLOT_CYCLES)
)(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // Internal register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Lock bit held by the main configuration register
   input wire logic config_lock_in,
   // Per drive behaviour codes and temperature flags
   input wire fpr_bhv_t drive_one_behaviour_in,
   input wire fpr_bhv_t drive_two_behaviour_in,
   input wire fpr_bhv_t drive_three_behaviour_in,
   input wire logic drive_one_below_start_in,
   input wire logic drive_two_below_start_in,
   input wire logic drive_three_below_start_in,
   // Calculated and minimum duties per drive
   input wire fpr_duty_t drive_one_calc_duty_in,
   input wire fpr_duty_t drive_two_calc_duty_in,
   input wire fpr_duty_t drive_three_calc_duty_in,
   input wire fpr_duty_t drive_one_min_duty_in,
   input wire fpr_duty_t drive_two_min_duty_in,
   input wire fpr_duty_t drive_three_min_duty_in,
   // Duty actually applied to each fan drive
   output fpr_duty_t fan_drive_one_out,
   output fpr_duty_t fan_drive_two_out,
   output fpr_duty_t fan_drive_three_out,
   // Speed inputs synchronised to drive three
   output logic speed_input_two_sync_out,
   output logic speed_input_three_sync_out,
   output logic speed_input_four_sync_out,
   // Raw views of the configuration registers
   output logic [7:0] acoustic_ramp_config_one_out,
   output logic [7:0] acoustic_ramp_config_two_out
);

   // All state of the top, registered as one word
   typedef struct packed {
      fpr_cfg_one_t cfg_one; // First configuration register
      logic [7:0] cfg_two; // Second configuration register
      fpr_slot_cnt_t slot_cnt; // Time slot divider
      logic slot_pulse; // One-cycle slot strobe
      logic [7:0] rdata; // Read data holding register
      fpr_duty_t duty_one; // Drive one output
      fpr_duty_t duty_two; // Drive two output
      fpr_duty_t duty_three; // Drive three output
      logic sync_two; // Speed input two gating
      logic sync_three; // Speed input three gating
      logic sync_four; // Speed input four gating
   } fpr_top_state_t;

   fpr_top_state_t state; // Registered state
   fpr_top_state_t next_state; // Next value

   fpr_duty_t target_one; // Drive one after floor select
   fpr_duty_t target_two; // Drive two after floor select
   fpr_duty_t target_three; // Drive three after floor select
   logic write_ok; // Write permitted this cycle

   fpr_ramp_if ramp_bus (); // Carrier to the ramp stepper

   // Floor select, drive one
   fpr_floor u_floor_one (
      .behaviour_in (drive_one_behaviour_in),
      .below_floor_in (drive_one_below_start_in),
      .floor_select_in (state.cfg_one.floor_one),
      .calc_duty_in (drive_one_calc_duty_in),
      .min_duty_in (drive_one_min_duty_in),
      .auto_out (),
      .target_out (target_one)
   );

   // Floor select, drive two
   fpr_floor u_floor_two (
      .behaviour_in (drive_two_behaviour_in),
      .below_floor_in (drive_two_below_start_in),
      .floor_select_in (state.cfg_one.floor_two),
      .calc_duty_in (drive_two_calc_duty_in),
      .min_duty_in (drive_two_min_duty_in),
      .auto_out (),
      .target_out (target_two)
   );

   // Floor select, drive three
   fpr_floor u_floor_three (
      .behaviour_in (drive_three_behaviour_in),
      .below_floor_in (drive_three_below_start_in),
      .floor_select_in (state.cfg_one.floor_three),
      .calc_duty_in (drive_three_calc_duty_in),
      .min_duty_in (drive_three_min_duty_in),
      .auto_out (),
      .target_out (target_three)
   );

   // Ramp request for drive one
   assign ramp_bus.target = target_one;
   assign ramp_bus.rate = state.cfg_one.rate;
   assign ramp_bus.enable = state.cfg_one.ramp_en;
   assign ramp_bus.slot_pulse = state.slot_pulse;

   // Drive one ramp stepper
   fpr_ramp u_ramp (
      .clock_in (clock_in),
      .sys_rst_in (sys_rst_in),
      .ramp (ramp_bus.step)
   );

   // Writes land only while the lock is clear
   always_comb begin
      write_ok = reg_wr_in && !config_lock_in;
   end

   // Next state of registers, divider, outputs
   always_comb begin
      next_state = state;
      next_state.slot_pulse = 1'b0;

      // Time slot divider; pulse once per slot
      if (state.slot_cnt >= (SLOT_CYCLES - 24'h00_0001)) begin
         next_state.slot_cnt = '0;
         next_state.slot_pulse = 1'b1;
      end else begin
         next_state.slot_cnt = state.slot_cnt + 24'h00_0001;
      end

      // Register writes, decoded by address
      if (write_ok) begin
         case (reg_addr_in)
            `FPR_ADDR_CFG_ONE: begin
               next_state.cfg_one = fpr_cfg_one_t'(reg_wdata_in);
            end
            `FPR_ADDR_CFG_TWO: begin
               next_state.cfg_two = reg_wdata_in;
            end
            default: begin
               // Other addresses belong elsewhere
            end
         endcase
      end

      // Register reads; foreign addresses read zero
      if (reg_rd_in) begin
         case (reg_addr_in)
            `FPR_ADDR_CFG_ONE: begin
               next_state.rdata = state.cfg_one;
            end
            `FPR_ADDR_CFG_TWO: begin
               next_state.rdata = state.cfg_two;
            end
            default: begin
               next_state.rdata = 8'h00;
            end
         endcase
      end

      // Drive one follows the stepper, others follow floor select
      next_state.duty_one = ramp_bus.duty;
      next_state.duty_two = target_two;
      next_state.duty_three = target_three;

      // Inputs three and four always share drive three
      next_state.sync_three = 1'b1;
      next_state.sync_four = 1'b1;
      // Input two joins only when selected
      next_state.sync_two = state.cfg_one.sync_sel;
   end

   // Register all state; reset to power-on values
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state <= '0;
         state.cfg_one <= fpr_cfg_one_t'(`FPR_CFG_ONE_RESET);
         state.cfg_two <= `FPR_CFG_TWO_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata_out = state.rdata;
   assign fan_drive_one_out = state.duty_one;
   assign fan_drive_two_out = state.duty_two;
   assign fan_drive_three_out = state.duty_three;
   assign speed_input_two_sync_out = state.sync_two;
   assign speed_input_three_sync_out = state.sync_three;
   assign speed_input_four_sync_out = state.sync_four;
   assign acoustic_ramp_config_one_out = state.cfg_one;
   assign acoustic_ramp_config_two_out = state.cfg_two;

endmodule : fpr_top

`default_nettype wire

// [tb/fpr_fan_model.sv]
// Behavioural fans on the three drives: speed creeps toward duty.
// Assumes duties change on the rising edge of clock_in.
`timescale 1ns/100ps
`default_nettype none

module fpr_fan_model (
   input wire logic clock_in,
   input wire logic [23:0] duties_in,
   output logic [23:0] speed_out
);
   // Rotors start at rest
   initial speed_out = 24'h00_0000;

   // Inertia: one count per clock, so a jump in duty is never instant
   always @(posedge clock_in) begin
      for (int i = 0; i < 3; i++) begin
         if (speed_out[8*i +: 8] < duties_in[8*i +: 8])
            speed_out[8*i +: 8] <= speed_out[8*i +: 8] + 8'h01;
         else if (speed_out[8*i +: 8] > duties_in[8*i +: 8])
            speed_out[8*i +: 8] <= speed_out[8*i +: 8] - 8'h01;
      end
   end
endmodule : fpr_fan_model

`default_nettype wire

// [tb/fpr_top_chk.sv]
// Checker for fpr_top: register, floor, speed sync and ramp relations.
// Bound to every fpr_top instance; sees only the top-level ports.
`timescale 1ns/100ps
`default_nettype none

module fpr_top_chk
   import fpr_pkg::*;
#(
   parameter fpr_slot_cnt_t SLOT_CYCLES = 24'h9C_6710
)(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic config_lock_in,
   input wire fpr_bhv_t drive_two_behaviour_in,
   input wire fpr_bhv_t drive_three_behaviour_in,
   input wire logic drive_one_below_start_in,
   input wire logic drive_two_below_start_in,
   input wire logic drive_three_below_start_in,
   input wire fpr_duty_t drive_one_calc_duty_in,
   input wire fpr_duty_t drive_three_min_duty_in,
   input wire fpr_duty_t fan_drive_one_out,
   input wire fpr_duty_t fan_drive_two_out,
   input wire fpr_duty_t fan_drive_three_out,
   input wire logic speed_input_two_sync_out,
   input wire logic speed_input_three_sync_out,
   input wire logic speed_input_four_sync_out,
   input wire logic [7:0] acoustic_ramp_config_one_out,
   input wire logic [7:0] acoustic_ramp_config_two_out
);
   // Increment per slot for each rate code
   localparam fpr_duty_t STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
      8'h08, 8'h0C, 8'h18, 8'h30};

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);

   // Codes 3, 4 and 7 bypass the temperature loop
   function automatic logic is_auto(input fpr_bhv_t b);
      return !(b == 3'h3 || b == 3'h4 || b == 3'h7);
   endfunction : is_auto

   // Ramp on with a steady rate; three cycles covers a registered enable
   sequence s_ramp_held;
      (acoustic_ramp_config_one_out[3]
         && $stable(acoustic_ramp_config_one_out[2:0])) [*3];
   endsequence

   // Ramp off, not below start, target steady
   sequence s_off_steady;
      (!acoustic_ramp_config_one_out[3] && !drive_one_below_start_in
         && $stable(drive_one_calc_duty_in)) [*3];
   endsequence

   // Step size judged by the rate held while the step was taken,
   // since a rewrite may land in the very cycle being checked
   chk_ramp_step_limit: assert property (
      s_ramp_held |=> ((fan_drive_one_out > $past(fan_drive_one_out)) ?
         fan_drive_one_out - $past(fan_drive_one_out) :
         $past(fan_drive_one_out) - fan_drive_one_out)
         <= STEPS[$past(acoustic_ramp_config_one_out[2:0])])
      else $error("drive one moved more than one increment");
   chk_ramp_off_jump: assert property (
      s_off_steady |=> fan_drive_one_out == $past(drive_one_calc_duty_in))
      else $error("drive one did not take its target");
   chk_two_floor_zero: assert property (
      is_auto(drive_two_behaviour_in) && drive_two_below_start_in
      && !acoustic_ramp_config_one_out[6] |=> fan_drive_two_out == 8'h00)
      else $error("drive two not off below start");
   chk_three_floor_min: assert property (
      is_auto(drive_three_behaviour_in) && drive_three_below_start_in
      && acoustic_ramp_config_one_out[7]
      |=> fan_drive_three_out == $past(drive_three_min_duty_in))
      else $error("drive three not at minimum below start");
   chk_write_reg_one: assert property (
      reg_wr_in && !config_lock_in && reg_addr_in == 8'h62
      |=> acoustic_ramp_config_one_out == $past(reg_wdata_in))
      else $error("write to first register lost");
   chk_write_reg_two: assert property (
      reg_wr_in && !config_lock_in && reg_addr_in == 8'h63
      |=> acoustic_ramp_config_two_out == $past(reg_wdata_in))
      else $error("write to second register lost");
   chk_lock_blocks_write: assert property (
      config_lock_in && reg_wr_in |=> $stable(acoustic_ramp_config_one_out)
      && $stable(acoustic_ramp_config_two_out))
      else $error("locked register changed");
   chk_sync_two_follow: assert property (
      speed_input_two_sync_out == $past(acoustic_ramp_config_one_out[4]))
      else $error("speed input two gating wrong");
   chk_sync_fixed_on: assert property (
      !$past(sys_rst_in)
      |-> speed_input_three_sync_out && speed_input_four_sync_out)
      else $error("speed inputs three and four not gated");
endmodule : fpr_top_chk

bind fpr_top fpr_top_chk #(.SLOT_CYCLES(SLOT_CYCLES)) chk_u (
   .clock_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
   .config_lock_in, .drive_two_behaviour_in, .drive_three_behaviour_in,
   .drive_one_below_start_in, .drive_two_below_start_in,
   .drive_three_below_start_in, .drive_one_calc_duty_in,
   .drive_three_min_duty_in, .fan_drive_one_out, .fan_drive_two_out,
   .fan_drive_three_out, .speed_input_two_sync_out,
   .speed_input_three_sync_out, .speed_input_four_sync_out,
   .acoustic_ramp_config_one_out, .acoustic_ramp_config_two_out);

`default_nettype wire

// [tb/fpr_top_tb.sv]
// Self-checking bench for fpr_top over its byte register port.
// Assumes a short slot of 4 cycles; fans modelled behaviourally.
`timescale 1ns/100ps
`default_nettype none

module fpr_top_tb;
   import fpr_pkg::*;
   // Increment per slot for each rate code
   localparam fpr_duty_t STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
      8'h08, 8'h0C, 8'h18, 8'h30};
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, config_lock_in = 1'b0;
   fpr_bhv_t drive_one_behaviour_in = 3'h0, drive_two_behaviour_in = 3'h0;
   fpr_bhv_t drive_three_behaviour_in = 3'h0;
   logic drive_one_below_start_in = 1'b1, drive_two_below_start_in = 1'b1;
   logic drive_three_below_start_in = 1'b1;
   fpr_duty_t drive_one_calc_duty_in = 8'h50, drive_two_calc_duty_in = 8'h50;
   fpr_duty_t drive_three_calc_duty_in = 8'h50;
   fpr_duty_t drive_one_min_duty_in = 8'h20, drive_two_min_duty_in = 8'h20;
   fpr_duty_t drive_three_min_duty_in = 8'h20;
   logic [7:0] reg_rdata_out;
   logic [7:0] acoustic_ramp_config_one_out, acoustic_ramp_config_two_out;
   fpr_duty_t fan_drive_one_out, fan_drive_two_out, fan_drive_three_out;
   logic speed_input_two_sync_out, speed_input_three_sync_out;
   logic speed_input_four_sync_out;
   logic [23:0] fan_speed; // Modelled rotor speeds, drive three on top
   int miscompares = 0, comparisons = 0;

   // 50 MHz clock
   always #10 clock_in = ~clock_in;

   // Short slot keeps the slowest ramp under a thousand cycles
   fpr_top #(.SLOT_CYCLES(24'h00_0004)) dut_u (
      .clock_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .config_lock_in, .drive_one_behaviour_in,
      .drive_two_behaviour_in, .drive_three_behaviour_in,
      .drive_one_below_start_in, .drive_two_below_start_in,
      .drive_three_below_start_in, .drive_one_calc_duty_in,
      .drive_two_calc_duty_in, .drive_three_calc_duty_in,
      .drive_one_min_duty_in, .drive_two_min_duty_in,
      .drive_three_min_duty_in, .fan_drive_one_out, .fan_drive_two_out,
      .fan_drive_three_out, .speed_input_two_sync_out,
      .speed_input_three_sync_out, .speed_input_four_sync_out,
      .acoustic_ramp_config_one_out, .acoustic_ramp_config_two_out);

   // Fans on the drive outputs
   fpr_fan_model fans_u (.clock_in(clock_in),
      .duties_in({fan_drive_three_out, fan_drive_two_out, fan_drive_one_out}),
      .speed_out(fan_speed));

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   // Wait n edges, then let their updates land
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
   endtask : wr

   // One-cycle read strobe; data lands one edge later
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      #1 check(reg_rdata_out, exp);
   endtask : rd

   // Single exit point
   task automatic give_verdict;
      $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   initial begin
      fpr_duty_t exp;
      fpr_duty_t prev;
      int n;
      repeat (5) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rd(8'h62, 8'h00);
      rd(8'h63, 8'h00);
      wr(8'h63, 8'hA5);
      rd(8'h63, 8'hA5);
      rd(8'h64, 8'h00);
      // Speed input gating both ways
      wr(8'h62, 8'h10);
      tick(2);
      check(8'(speed_input_two_sync_out), 8'h01);
      check({6'h00, speed_input_three_sync_out,
         speed_input_four_sync_out}, 8'h03);
      wr(8'h62, 8'h00);
      tick(2);
      check(8'(speed_input_two_sync_out), 8'h00);
      check({6'h00, speed_input_three_sync_out,
         speed_input_four_sync_out}, 8'h03);
      // Every behaviour code with each floor choice, all below start
      for (int b = 0; b < 8; b++) begin
         for (int f = 0; f < 2; f++) begin
            wr(8'h62, (f == 1) ? 8'hE0 : 8'h00);
            drive_one_behaviour_in <= 3'(b);
            drive_two_behaviour_in <= 3'(b);
            drive_three_behaviour_in <= 3'(b);
            tick(4);
            exp = (b == 3 || b == 4 || b == 7) ? 8'h50 :
               ((f == 1) ? 8'h20 : 8'h00);
            check(fan_drive_one_out, exp);
            check(fan_drive_two_out, exp);
            check(fan_drive_three_out, exp);
         end
      end
      drive_one_behaviour_in <= 3'h0;
      drive_one_below_start_in <= 1'b0;
      // Each rate code: ramp 0 to 0xC0 and count the steps
      for (int r = 0; r < 8; r++) begin
         drive_one_calc_duty_in <= 8'h00;
         wr(8'h62, 8'h00);
         tick(4);
         check(fan_drive_one_out, 8'h00);
         wr(8'h62, 8'h08 | 8'(r));
         drive_one_calc_duty_in <= 8'hC0;
         prev = 8'h00;
         n = 0;
         for (int i = 0; i < 2000 && prev !== 8'hC0; i++) begin
            tick(1);
            if (fan_drive_one_out !== prev) begin
               exp = (8'hC0 - prev < STEPS[r]) ? 8'hC0 - prev : STEPS[r];
               check(fan_drive_one_out - prev, exp);
               prev = fan_drive_one_out;
               n++;
            end
         end
         if (prev !== 8'hC0) begin
            miscompares++;
            give_verdict();
         end
         check(8'(n), 8'((192 + STEPS[r] - 1) / STEPS[r]));
      end
      // Ramp off: new target taken at once
      wr(8'h62, 8'h00);
      drive_one_calc_duty_in <= 8'h10;
      tick(3);
      check(fan_drive_one_out, 8'h10);
      // Lock: both registers ignore writes
      config_lock_in <= 1'b1;
      wr(8'h62, 8'hFF);
      wr(8'h63, 8'h00);
      rd(8'h62, 8'h00);
      rd(8'h63, 8'hA5);
      config_lock_in <= 1'b0;
      wr(8'h62, 8'h5A);
      rd(8'h62, 8'h5A);
      // Rotors settle on the steady duties after their inertia
      tick(300);
      check(fan_speed[7:0], 8'h10);
      check(fan_speed[23:16], 8'h50);
      give_verdict();
   end
endmodule : fpr_top_tb

`default_nettype wire
